// [otp_command_engine.v]
// transport-layer command engine of a one-time-programmable memory
// Functional notes
// - read memory f0: address, then bytes lsb first
// - after last byte one inverted crc, then ones
// - end-of-memory crc covers command, address, data
// - extended read a5: redirection byte, then its crc
// - page-end crc covers that page's data only
// - next page: redirection byte, crc of it alone
// - read status aa: crc after each 8-byte page
// - first status crc includes command and address
// - crc accumulator cleared at every read start
// - write memory 0f: address, data, sixteen-slot crc
// - program pulse stores byte, eight-slot readback
// - not last byte: address advances, await data
// - later write crc seeded with incremented address
// - write status 55 same flow on status memory
// - gap writes ignored; after top byte, halt until link reset
// - out-of-range upper address bits forced to zero
// - erased cells read ffh; bits only clear
// - every crc sent inverted, low byte first
// - status map: protect, bitmap, redirection at 100h
// - status gaps read all ones
`timescale 1ns/1ns
`include "otp_engine_defs.vh"
module otp_command_engine #(
	parameter MEM_AW     = 9,
	parameter DATA_PAGES = 16,
	parameter FIFO_DEPTH = 4,
	parameter FIFO_AW    = 2
) (
	// clock and reset
	input  wire       clk,
	input  wire       reset_n,
	// link layer events
	input  wire       bus_reset,
	input  wire       prog_pulse,
	input  wire       read_slot,
	// bytes written by the master
	input  wire [7:0] rx_byte,
	input  wire       rx_valid,
	output wire       rx_ready,
	// bit returned in the next read slot
	output wire       tx_bit,
	output wire       busy
);

	localparam MEM_BYTES = 1 << MEM_AW;

	localparam [3:0] ST_IDLE  = 4'h0;
	localparam [3:0] ST_ALO   = 4'h1;
	localparam [3:0] ST_AHI   = 4'h2;
	localparam [3:0] ST_RDAT  = 4'h3;
	localparam [3:0] ST_RCRC  = 4'h4;
	localparam [3:0] ST_ONES  = 4'h5;
	localparam [3:0] ST_XRED  = 4'h6;
	localparam [3:0] ST_XCRC  = 4'h7;
	localparam [3:0] ST_WDATA = 4'h8;
	localparam [3:0] ST_WCRC  = 4'h9;
	localparam [3:0] ST_WPROG = 4'ha;
	localparam [3:0] ST_WVER  = 4'hb;
	localparam [3:0] ST_HALT  = 4'hc;

	// ************************************************************
	// storage
	// ************************************************************
	reg [7:0] data_mem [0:MEM_BYTES-1];
	reg [7:0] stat_mem [0:511];
	integer   k;

	initial begin
		for (k = 0; k < MEM_BYTES; k = k + 1)
			data_mem[k] = `ERASED_BYTE;
		for (k = 0; k < 512; k = k + 1)
			stat_mem[k] = `ERASED_BYTE;
	end

	// ************************************************************
	// crc16 byte step
	// ************************************************************
	function [15:0] crc_byte;
		input [15:0] crc_in;
		input [7:0]  din;
		integer      b;
		reg   [15:0] c;
		begin
			c = crc_in;
			for (b = 0; b < 8; b = b + 1) begin
				if (c[0] ^ din[b])
					c = (c >> 1) ^ `CRC_POLY_REFL;
				else
					c = c >> 1;
			end
			crc_byte = c;
		end
	endfunction

	// status bytes that exist in silicon for the page count
	function stat_present;
		input [8:0] a;
		begin
			if (a >= `STAT_REDIR_BASE)
				stat_present = ((a - `STAT_REDIR_BASE) < DATA_PAGES);
			else if (a < `STAT_GROUP_END)
				stat_present = ({4'h0, a[4:0]} < ((DATA_PAGES + 7) / 8));
			else
				stat_present = 1'b0;
		end
	endfunction

	// ************************************************************
	// receive fifo
	// ************************************************************
	wire [7:0] fifo_data;
	wire       fifo_valid;
	wire       fifo_take;
	reg  [3:0] state_reg;

	assign fifo_take = (state_reg == ST_IDLE) || (state_reg == ST_ALO) ||
		(state_reg == ST_AHI) || (state_reg == ST_WDATA);

	byte_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) rx_fifo (
		.clk       (clk),
		.reset_n   (reset_n),
		.flush     (bus_reset),
		.in_data   (rx_byte),
		.in_valid  (rx_valid),
		.in_ready  (rx_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_take)
	);

	// ************************************************************
	// sequencer
	// ************************************************************
	reg  [7:0]  cmd_reg;
	reg  [7:0]  addr_lo_reg;
	reg  [8:0]  addr_reg;
	reg  [15:0] crc_reg;
	reg  [15:0] tx_sr_reg;
	reg  [4:0]  tx_left_reg;
	reg  [7:0]  wbuf_reg;

	wire        is_stat  = (cmd_reg == `CMD_READ_STATUS) || (cmd_reg == `CMD_WRITE_STATUS);
	wire [8:0]  addr_mask = is_stat ? `STAT_SPACE_LAST : MEM_BYTES[8:0] - 9'h001;
	wire [8:0]  addr_last = addr_mask;
	wire [8:0]  addr_inc  = addr_reg + 9'h001;
	wire        stat_ok   = stat_present(addr_reg);
	wire [7:0]  cur_byte  = is_stat ? (stat_ok ? stat_mem[addr_reg] : `ERASED_BYTE)
		: data_mem[addr_reg[MEM_AW-1:0]];
	wire [8:0]  redir_addr = `STAT_REDIR_BASE + {4'h0, addr_reg[MEM_AW-1:5]};
	wire [8:0]  redir_next = `STAT_REDIR_BASE + {4'h0, addr_inc[MEM_AW-1:5]};
	wire [7:0]  redir_cur  = stat_present(redir_addr) ? stat_mem[redir_addr] : `ERASED_BYTE;
	wire [7:0]  redir_nxt  = stat_present(redir_next) ? stat_mem[redir_next] : `ERASED_BYTE;
	wire        last_bit   = read_slot && (tx_left_reg == 5'd1);
	wire [15:0] crc_sent   = crc_byte(crc_reg, (state_reg == ST_XRED) ? redir_cur : cur_byte);
	wire [8:0]  addr_rx    = {fifo_data[0], addr_lo_reg} & addr_mask;
	wire [7:0]  prog_val   = cur_byte & wbuf_reg;
	wire        prog_ok    = !is_stat || stat_ok;

	assign tx_bit = tx_sr_reg[0];
	assign busy   = (state_reg != ST_IDLE) && (state_reg != ST_HALT);

	always @(posedge clk) begin
		if ((state_reg == ST_WPROG) && prog_pulse && prog_ok && !bus_reset) begin
			if (is_stat)
				stat_mem[addr_reg] <= prog_val;
			else
				data_mem[addr_reg[MEM_AW-1:0]] <= prog_val;
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg   <= ST_IDLE;
			cmd_reg     <= 8'h00;
			addr_lo_reg <= 8'h00;
			addr_reg    <= 9'h000;
			crc_reg     <= `CRC_CLEAR;
			tx_sr_reg   <= 16'hffff;
			tx_left_reg <= 5'd0;
			wbuf_reg    <= 8'hff;
		end else if (bus_reset) begin
			state_reg   <= ST_IDLE;
			tx_sr_reg   <= 16'hffff;
			tx_left_reg <= 5'd0;
		end else begin
			if (read_slot && (tx_left_reg != 5'd0)) begin
				tx_sr_reg   <= {1'b1, tx_sr_reg[15:1]};
				tx_left_reg <= tx_left_reg - 5'd1;
			end
			case (state_reg)
			ST_IDLE: begin
				if (fifo_valid) begin
					cmd_reg <= fifo_data;
					crc_reg <= crc_byte(`CRC_CLEAR, fifo_data);
					if ((fifo_data == `CMD_READ_MEM) || (fifo_data == `CMD_READ_EXT) ||
						(fifo_data == `CMD_READ_STATUS) || (fifo_data == `CMD_WRITE_MEM) ||
						(fifo_data == `CMD_WRITE_STATUS))
						state_reg <= ST_ALO;
					else
						state_reg <= ST_HALT;
				end
			end
			ST_ALO: begin
				if (fifo_valid) begin
					addr_lo_reg <= fifo_data;
					state_reg   <= ST_AHI;
				end
			end
			ST_AHI: begin
				if (fifo_valid) begin
					addr_reg <= addr_rx;
					crc_reg  <= crc_byte(crc_byte(crc_reg, addr_rx[7:0]),
						{7'h00, addr_rx[8]});
					tx_left_reg <= 5'd8;
					if (cmd_reg == `CMD_READ_EXT) begin
						tx_sr_reg <= {8'hff, stat_mem[`STAT_REDIR_BASE +
							{4'h0, addr_rx[MEM_AW-1:5]}]};
						state_reg <= ST_XRED;
					end else if ((cmd_reg == `CMD_WRITE_MEM) ||
						(cmd_reg == `CMD_WRITE_STATUS)) begin
						tx_left_reg <= 5'd0;
						state_reg   <= ST_WDATA;
					end else begin
						tx_sr_reg <= {8'hff, (cmd_reg == `CMD_READ_STATUS) &&
							!stat_present(addr_rx) ? `ERASED_BYTE :
							((cmd_reg == `CMD_READ_STATUS) ? stat_mem[addr_rx] :
							data_mem[addr_rx[MEM_AW-1:0]])};
						state_reg <= ST_RDAT;
					end
				end
			end
			ST_RDAT: begin
				if (last_bit) begin
					crc_reg <= crc_sent;
					if ((cmd_reg == `CMD_READ_MEM) ? (addr_reg == addr_last) :
						(cmd_reg == `CMD_READ_STATUS) ?
						(addr_reg[2:0] == `STAT_PAGE_MASK) :
						(addr_reg[4:0] == `DATA_PAGE_MASK)) begin
						tx_sr_reg   <= ~crc_sent;
						tx_left_reg <= 5'd16;
						state_reg   <= ST_RCRC;
					end else begin
						addr_reg    <= addr_inc;
						tx_sr_reg   <= {8'hff, is_stat ?
							(stat_present(addr_inc) ? stat_mem[addr_inc] : `ERASED_BYTE) :
							data_mem[addr_inc[MEM_AW-1:0]]};
						tx_left_reg <= 5'd8;
					end
				end
			end
			ST_RCRC: begin
				if (last_bit) begin
					crc_reg <= `CRC_CLEAR;
					if ((cmd_reg == `CMD_READ_MEM) || (addr_reg == addr_last)) begin
						tx_sr_reg   <= 16'hffff;
						tx_left_reg <= 5'd0;
						state_reg   <= ST_ONES;
					end else if (cmd_reg == `CMD_READ_EXT) begin
						addr_reg    <= addr_inc;
						tx_sr_reg   <= {8'hff, redir_nxt};
						tx_left_reg <= 5'd8;
						state_reg   <= ST_XRED;
					end else begin
						addr_reg    <= addr_inc;
						tx_sr_reg   <= {8'hff, stat_present(addr_inc) ?
							stat_mem[addr_inc] : `ERASED_BYTE};
						tx_left_reg <= 5'd8;
						state_reg   <= ST_RDAT;
					end
				end
			end
			ST_XRED: begin
				if (last_bit) begin
					tx_sr_reg   <= ~crc_sent;
					tx_left_reg <= 5'd16;
					state_reg   <= ST_XCRC;
				end
			end
			ST_XCRC: begin
				if (last_bit) begin
					crc_reg     <= `CRC_CLEAR;
					tx_sr_reg   <= {8'hff, cur_byte};
					tx_left_reg <= 5'd8;
					state_reg   <= ST_RDAT;
				end
			end
			ST_WDATA: begin
				if (fifo_valid) begin
					wbuf_reg    <= fifo_data;
					crc_reg     <= crc_byte(crc_reg, fifo_data);
					tx_sr_reg   <= ~crc_byte(crc_reg, fifo_data);
					tx_left_reg <= 5'd16;
					state_reg   <= ST_WCRC;
				end
			end
			ST_WCRC: begin
				if (last_bit)
					state_reg <= ST_WPROG;
			end
			ST_WPROG: begin
				if (prog_pulse) begin
					tx_sr_reg   <= {8'hff, prog_ok ? prog_val : cur_byte};
					tx_left_reg <= 5'd8;
					state_reg   <= ST_WVER;
				end
			end
			ST_WVER: begin
				if (last_bit) begin
					if (addr_reg == addr_last) begin
						state_reg <= ST_HALT;
					end else begin
						addr_reg  <= addr_inc;
						crc_reg   <= {7'h00, addr_inc};
						state_reg <= ST_WDATA;
					end
				end
			end
			ST_ONES, ST_HALT: begin
				tx_sr_reg   <= 16'hffff;
				tx_left_reg <= 5'd0;
			end
			default: begin
				state_reg <= ST_HALT;
			end
			endcase
		end
	end

endmodule // otp_command_engine

// [otp_engine_defs.vh]
// shared constants for the one-time-programmable memory command engine
`ifndef OTP_ENGINE_DEFS_VH
`define OTP_ENGINE_DEFS_VH

// ************************************************************
// command codes
// ************************************************************
`define CMD_READ_MEM      8'hf0
`define CMD_READ_EXT      8'ha5
`define CMD_READ_STATUS   8'haa
`define CMD_WRITE_MEM     8'h0f
`define CMD_WRITE_STATUS  8'h55

// ************************************************************
// crc16, reflected form of x^16+x^15+x^2+1
// ************************************************************
`define CRC_POLY_REFL     16'ha001
`define CRC_CLEAR         16'h0000

// ************************************************************
// memory layout
// ************************************************************
`define ERASED_BYTE       8'hff
`define DATA_PAGE_MASK    5'h1f
`define STAT_PAGE_MASK    3'h7
`define STAT_SPACE_LAST   9'h1ff
`define STAT_WP_BASE      9'h000
`define STAT_RP_BASE      9'h020
`define STAT_MAP_BASE     9'h040
`define STAT_GROUP_END    9'h060
`define STAT_REDIR_BASE   9'h100

`endif

// [byte_fifo.v]
// small first-word-fall-through fifo for received bytes
`timescale 1ns/1ns
module byte_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	// clock and reset
	input  wire             clk,
	input  wire             reset_n,
	input  wire             flush,
	// fill side
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	// drain side
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);

	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;

	wire push = in_valid && in_ready;
	wire pop  = out_valid && out_ready;

	assign in_ready  = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data  = store[rd_ptr_reg];

	always @(posedge clk) begin
		if (push)
			store[wr_ptr_reg] <= in_data;
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule // byte_fifo

// [otp_engine_properties.sv]
// port assertions for the memory command engine
`timescale 1ns/1ns
module otp_engine_checker (
	// clock and reset
	input wire logic       clk,
	input wire logic       reset_n,
	// link events
	input wire logic       bus_reset,
	input wire logic       prog_pulse,
	input wire logic       read_slot,
	// bytes from the master
	input wire logic [7:0] rx_byte,
	input wire logic       rx_valid,
	input wire logic       rx_ready,
	// answer
	input wire logic       tx_bit,
	input wire logic       busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	reset_quiet_a: assert property ($rose(reset_n) |-> tx_bit && !busy && rx_ready)
		else $error("engine not quiet after reset");
	idle_ones_a: assert property (!busy && !$past(busy) |-> tx_bit)
		else $error("idle engine drives a zero");
	link_reset_idle_a: assert property (bus_reset |=> !busy && tx_bit)
		else $error("link reset did not idle the engine");
	link_reset_flush_a: assert property (bus_reset |=> rx_ready)
		else $error("link reset left the fifo full");
	full_cause_a: assert property ($fell(rx_ready) |-> $past(rx_valid))
		else $error("fifo filled without a push");
	busy_end_a: assert property ($fell(busy) |-> $past(bus_reset) || $past(read_slot))
		else $error("transfer ended without slot or reset");
	prog_idle_a: assert property (!busy && prog_pulse && !$past(rx_valid) |=> !busy && tx_bit)
		else $error("program pulse woke an idle engine");
	slot_idle_a: assert property (!busy && read_slot |=> tx_bit ##1 tx_bit)
		else $error("idle slot returned a zero");
	busy_start_a: assert property ($rose(busy) |->
		$past(rx_valid) || $past(rx_valid, 2) || $past(rx_valid, 3))
		else $error("transfer began without a byte");
endmodule // otp_engine_checker

bind otp_command_engine otp_engine_checker chk (.clk(clk), .reset_n(reset_n),
	.bus_reset(bus_reset), .prog_pulse(prog_pulse), .read_slot(read_slot),
	.rx_byte(rx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready),
	.tx_bit(tx_bit), .busy(busy));

// [bus_master_model.sv]
// behavioural single-wire bus master driving the engine's link side
`timescale 1ns/1ns
module bus_master_model (
	// clock
	input  wire logic       clk,
	// answers from the engine
	input  wire logic       rx_ready,
	input  wire logic       tx_bit,
	// link events
	output logic            bus_reset,
	output logic            prog_pulse,
	output logic            read_slot,
	// bytes to the engine
	output logic [7:0]      rx_byte,
	output logic            rx_valid
);
	logic [15:0] crc;
	logic [15:0] arg;
	logic [15:0] res;
	logic        req = 1'b0;
	int          op = 0;

	initial begin
		bus_reset = 1'b0;
		prog_pulse = 1'b0;
		read_slot = 1'b0;
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		crc = 16'h0000;
	end

	// ************************************************************
	// master's own crc16, reflected, lsb first
	// ************************************************************
	function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			r = r[0] ? (r >> 1) ^ 16'ha001 : r >> 1;
		return r;
	endfunction

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	// byte held until the fifo takes it
	task automatic drv_put(input logic [7:0] b);
		int n;
		n = 0;
		rx_byte = b;
		rx_valid = 1'b1;
		crc = crc8(crc, b);
		while (rx_ready !== 1'b1 && n < 200) begin
			step();
			n++;
		end
		step();
	endtask

	// released byte lines show a changed value
	task automatic drv_quiet();
		rx_valid = 1'b0;
		rx_byte = ~rx_byte;
		repeat (4) step();
	endtask

	task automatic drv_bits(input int n, output logic [15:0] v);
		v = 16'hffff;
		for (int i = 0; i < n; i++) begin
			read_slot = 1'b1;
			v[i] = tx_bit;
			step();
			read_slot = 1'b0;
			step();
		end
	endtask

	// one-cycle program pulse, or link reset
	task automatic drv_pulse(input logic prog);
		if (prog)
			prog_pulse = 1'b1;
		else
			bus_reset = 1'b1;
		step();
		prog_pulse = 1'b0;
		bus_reset = 1'b0;
		repeat (3) step();
	endtask

	// ************************************************************
	// the model's own process performs every link request
	// ************************************************************
	initial forever begin
		wait (req);
		case (op)
		1: drv_put(arg[7:0]);
		2: drv_bits(arg, res);
		3: drv_pulse(arg[0]);
		default: drv_quiet();
		endcase
		req = 1'b0;
	end

	// request handed to the model, returns once it is done
	task automatic call(input int o, input logic [15:0] a);
		op = o;
		arg = a;
		req = 1'b1;
		wait (req == 1'b0);
	endtask

	task automatic put(input logic [7:0] b);
		call(1, {8'h00, b});
	endtask

	task automatic bits(input int n, output logic [15:0] v);
		call(2, n[15:0]);
		v = res;
	endtask

	task automatic pulse(input logic prog);
		call(3, {15'h0000, prog});
	endtask

	task automatic quiet();
		call(4, 16'h0000);
	endtask
endmodule // bus_master_model

// [testbench.sv]
// self-checking testbench of the memory command engine
`timescale 1ns/1ns
`include "otp_engine_defs.vh"
module testbench;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        bus_reset, prog_pulse, read_slot, rx_valid, rx_ready, tx_bit, busy;
	logic [7:0]  rx_byte;
	logic [7:0]  got;
	int          n_fail = 0;
	int          samples_checked = 0;

	always #10 clk = ~clk;

	otp_command_engine dut (.clk(clk), .reset_n(reset_n), .bus_reset(bus_reset),
		.prog_pulse(prog_pulse), .read_slot(read_slot), .rx_byte(rx_byte),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .tx_bit(tx_bit), .busy(busy));
	bus_master_model m (.clk(clk), .rx_ready(rx_ready), .tx_bit(tx_bit),
		.bus_reset(bus_reset), .prog_pulse(prog_pulse), .read_slot(read_slot),
		.rx_byte(rx_byte), .rx_valid(rx_valid));

	// ************************************************************
	// shared steps
	// ************************************************************
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic getb(input logic [7:0] exp, input string what);
		logic [15:0] v;
		m.bits(8, v);
		got = v[7:0];
		m.crc = m.crc8(m.crc, v[7:0]);
		check(what, v, {8'hff, exp});
	endtask

	task automatic getcrc(input string what);
		logic [15:0] v;
		m.bits(16, v);
		check(what, v, ~m.crc);
		m.crc = 16'h0000;
	endtask

	task automatic open(input logic [7:0] c, input logic [15:0] a);
		m.crc = 16'h0000;
		m.put(c);
		m.put(a[7:0]);
		m.put(a[15:8]);
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
		open(c, a);
		m.put(d);
		m.quiet();
	endtask

	task automatic burn(input logic [7:0] exp);
		getcrc("write crc");
		m.pulse(1'b1);
		getb(exp, "readback");
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_read_end();
		open(`CMD_READ_MEM, 16'h01fe);
		m.quiet();
		getb(8'hff, "erased byte");
		getb(8'hff, "last byte");
		getcrc("end crc");
		getb(8'hff, "after end");
		m.pulse(1'b0);
		$display("test read_end done");
	endtask

	task automatic t_write();
		wr(`CMD_WRITE_MEM, 16'h0010, 8'ha5);
		burn(8'ha5);
		m.crc = 16'h0011;
		m.put(8'h3c);
		m.quiet();
		burn(8'h3c);
		m.pulse(1'b0);
		wr(`CMD_WRITE_MEM, 16'h0010, 8'hf0);
		burn(8'ha0);
		m.pulse(1'b0);
		$display("test write done");
	endtask

	task automatic t_status();
		wr(`CMD_WRITE_STATUS, 16'h0100, 8'hfd);
		burn(8'hfd);
		m.pulse(1'b0);
		wr(`CMD_WRITE_STATUS, 16'h0080, 8'h00);
		burn(8'hff);
		m.pulse(1'b0);
		open(`CMD_READ_STATUS, 16'h0006);
		m.quiet();
		getb(8'hff, "status gap");
		getb(8'hff, "status gap");
		getcrc("first status crc");
		for (int i = 0; i < 8; i++)
			getb(8'hff, "status page");
		getcrc("later status crc");
		m.pulse(1'b0);
		$display("test status done");
	endtask

	task automatic t_ext();
		open(`CMD_READ_EXT, 16'h001e);
		m.quiet();
		getb(8'hfd, "redirection");
		check("newer page", {8'h00, ~got}, 16'h0002);
		getcrc("redirection crc");
		getb(8'hff, "page data");
		getb(8'hff, "page data");
		getcrc("page crc");
		getb(8'hff, "next redirection");
		getcrc("next redirection crc");
		m.pulse(1'b0);
		$display("test extended done");
	endtask

	task automatic t_fifo();
		open(`CMD_READ_MEM, 16'h0000);
		m.quiet();
		for (int i = 0; i < 4; i++)
			m.put(8'h00);
		check("fifo full", {15'h0000, rx_ready}, 16'h0000);
		m.quiet();
		getb(8'hff, "stream while full");
		m.pulse(1'b0);
		check("fifo flushed", {15'h0000, rx_ready}, 16'h0001);
		$display("test fifo done");
	endtask

	task automatic t_top();
		logic [15:0] v;
		logic [15:0] e;
		wr(`CMD_WRITE_MEM, 16'h03fe, 8'h00);
		e = m.crc8(m.crc8(m.crc8(m.crc8(16'h0000, `CMD_WRITE_MEM), 8'hfe), 8'h01), 8'h00);
		m.bits(16, v);
		check("masked address crc", v, ~e);
		check("mismatch seen", {15'h0000, v == ~m.crc}, 16'h0000);
		m.pulse(1'b0);
		wr(`CMD_WRITE_MEM, 16'h01ff, 8'h77);
		burn(8'h77);
		repeat (3) m.step();
		check("halted busy", {15'h0000, busy}, 16'h0000);
		m.pulse(1'b1);
		getb(8'hff, "halted slot");
		m.pulse(1'b0);
		m.put(8'h33);
		open(`CMD_READ_MEM, 16'h0010);
		m.quiet();
		getb(8'hff, "after unknown command");
		m.pulse(1'b0);
		$display("test top done");
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk);
		#1;
		reset_n = 1'b1;
		m.step();
		t_read_end();
		t_write();
		t_status();
		t_ext();
		t_fifo();
		t_top();
		conclude();
	end

	initial begin
		#1000000;
		n_fail++;
		conclude();
	end
endmodule // testbench
